// ==== rtl/panel_pkg.sv ====
// Purpose: shared constants for the converter front-panel display
// Assumes: 100 MHz ref_clk_i, segment bits ordered dp,g,f,e,d,c,b,a
// Notes:   long counts are top-level parameters defaulting to these values
package panel_pkg;

  // clock and timing
  localparam int CLK_KHZ         = 100_000;
  localparam int DEBOUNCE_MS     = 10;
  localparam int DEBOUNCE_CYC    = DEBOUNCE_MS * CLK_KHZ;
  localparam int BLINK_MS        = 250;
  localparam int BLINK_CYC       = BLINK_MS * CLK_KHZ;
  localparam int ALT_MS          = 500;
  localparam int ALT_CYC         = ALT_MS * CLK_KHZ;

  // display limits
  localparam logic [9:0] LIM_999 = 10'h3E7;
  localparam logic [9:0] LIM_400 = 10'h190;
  localparam logic [9:0] LIM_300 = 10'h12C;

  // navigation sizes
  localparam logic [2:0] ITEM_LAST   = 3'h7;
  localparam logic [1:0] DIAG_LAST   = 2'h3;
  localparam logic [4:0] PARAM_LAST  = 5'h12;
  localparam logic [1:0] DIAG_IO     = 2'h0;
  localparam logic [1:0] DIAG_FORCE  = 2'h1;
  localparam logic [1:0] DIAG_VER_LO = 2'h2;

  // version numbers, values arbitrary
  localparam logic [9:0] SW_VER_LO   = 10'h00B;
  localparam logic [9:0] SW_VER_HI   = 10'h016;

  // avalon register byte offsets and reset values
  localparam logic [3:0] OFS_CTRL    = 4'h0;
  localparam logic [3:0] OFS_STATUS  = 4'h4;
  localparam logic [3:0] OFS_IO      = 4'h8;
  localparam logic       CTRL_RST    = 1'b0;

  // segment patterns
  localparam logic [7:0] CH_BLANK = 8'h00;
  localparam logic [7:0] CH_DASH  = 8'h40;
  localparam logic [7:0] CH_R     = 8'h50;
  localparam logic [7:0] CH_O     = 8'h5C;
  localparam logic [7:0] CH_F     = 8'h71;
  localparam logic [7:0] CH_N     = 8'h54;
  localparam logic [7:0] CH_P     = 8'h73;
  localparam logic [7:0] CH_C     = 8'h39;
  localparam logic [7:0] CH_T     = 8'h78;
  localparam logic [7:0] CH_J     = 8'h1E;
  localparam logic [7:0] CH_B     = 8'h7C;
  localparam logic [7:0] CH_L     = 8'h38;
  localparam logic [7:0] CH_A     = 8'h77;
  localparam logic [7:0] CH_1     = 8'h06;
  localparam logic [7:0] CH_2     = 8'h5B;
  localparam logic [7:0] CH_DP    = 8'h80;

  typedef enum logic [3:0]
  {
    MODE_STATUS = 4'b0001,
    MODE_DIAG   = 4'b0010,
    MODE_ALARM  = 4'b0100,
    MODE_PARAM  = 4'b1000
  } mode_e;

endpackage

// ==== rtl/panel_debounce.sv ====
// Purpose: one pushbutton filter giving a single press pulse
// Assumes: raw_i already synchronous to ref_clk_i
// Notes:   the input must stay unchanged CYCLES clocks to be accepted
module panel_debounce #(
  parameter int CYCLES = 16
) (
  input  wire logic ref_clk_i,
  input  wire logic rst_b_i,
  input  wire logic raw_i,
  output logic      press_o
);

  logic [31:0] cnt_reg;
  logic        stable_reg;

  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      cnt_reg    <= 32'h0000_0000;
      stable_reg <= 1'b0;
      press_o    <= 1'b0;
    end
    else
    begin
      press_o <= 1'b0;
      if (raw_i == stable_reg)
        cnt_reg <= 32'h0000_0000;
      else if (cnt_reg == 32'(CYCLES - 1))
      begin
        cnt_reg    <= 32'h0000_0000;
        stable_reg <= raw_i;
        press_o    <= raw_i;
      end
      else
        cnt_reg <= cnt_reg + 32'h0000_0001;
    end
  end

endmodule // panel_debounce

// ==== rtl/panel_digit_enc.sv ====
// Purpose: decimal value to three seven-segment patterns
// Assumes: value_i never above 999
// Notes:   purely combinational, leading zeros are kept
module panel_digit_enc (
  input  wire logic [9:0] value_i,
  output logic      [7:0] seg2_o,
  output logic      [7:0] seg1_o,
  output logic      [7:0] seg0_o
);

  function automatic logic [7:0] seg_of(input logic [3:0] d);
    case (d)
      4'h0:    seg_of = 8'h3F;
      4'h1:    seg_of = 8'h06;
      4'h2:    seg_of = 8'h5B;
      4'h3:    seg_of = 8'h4F;
      4'h4:    seg_of = 8'h66;
      4'h5:    seg_of = 8'h6D;
      4'h6:    seg_of = 8'h7D;
      4'h7:    seg_of = 8'h07;
      4'h8:    seg_of = 8'h7F;
      4'h9:    seg_of = 8'h6F;
      default: seg_of = 8'h40;
    endcase
  endfunction

  logic [3:0] hund;
  logic [3:0] tens;
  logic [3:0] ones;

  always_comb
  begin
    hund   = 4'(value_i / 10'h064);
    tens   = 4'((value_i / 10'h00A) % 10'h00A);
    ones   = 4'(value_i % 10'h00A);
    seg2_o = seg_of(hund);
    seg1_o = seg_of(tens);
    seg0_o = seg_of(ones);
  end

endmodule // panel_digit_enc

// ==== rtl/converter_front_panel_display.sv ====
// Purpose: front-panel display and pushbutton logic of the converter
// Assumes: all inputs synchronous to ref_clk_i, buttons active high
// Notes:   measurement inputs arrive already averaged by control logic
module converter_front_panel_display #(
  parameter int DEBOUNCE_CYCLES = panel_pkg::DEBOUNCE_CYC,
  parameter int BLINK_CYCLES    = panel_pkg::BLINK_CYC,
  parameter int ALT_CYCLES      = panel_pkg::ALT_CYC
) (
  input  wire logic        ref_clk_i,
  input  wire logic        rst_b_i,
  input  wire logic        btn_mode_i,
  input  wire logic        btn_up_i,
  input  wire logic        btn_down_i,
  input  wire logic        btn_set_i,
  input  wire logic        drive_pairing_i,
  input  wire logic        init_done_i,
  input  wire logic        servo_on_i,
  input  wire logic        bus_established_i,
  input  wire logic        forced_stop_input_i,
  input  wire logic        alarm_raise_i,
  input  wire logic [6:0]  alarm_code_i,
  input  wire logic        alarm_cause_i,
  input  wire logic [9:0]  bus_voltage_i,
  input  wire logic [9:0]  eff_load_i,
  input  wire logic [9:0]  peak_load_i,
  input  wire logic [9:0]  regen_load_i,
  input  wire logic [13:0] power_now_i,
  input  wire logic [9:0]  energy_kwh_i,
  input  wire logic [9:0]  energy_mwh_i,
  input  wire logic [7:0]  io_connector_in_i,
  input  wire logic [7:0]  do_normal_i,
  input  wire logic [3:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  output logic      [7:0]  seg_digit2_o,
  output logic      [7:0]  seg_digit1_o,
  output logic      [7:0]  seg_digit0_o,
  output logic      [7:0]  io_connector_out_o,
  output logic             run_enable_o,
  output logic             alarm_active_o,
  output logic             ready_on_o
);

  panel_pkg::mode_e mode_reg;
  logic [3:0]  press;
  logic [3:0]  btn_raw;
  logic        p_mode;
  logic        p_up;
  logic        p_down;
  logic        p_set;
  logic [2:0]  item_reg;
  logic        show_value_reg;
  logic [1:0]  diag_reg;
  logic        force_on_reg;
  logic [7:0]  force_reg;
  logic [2:0]  do_sel_reg;
  logic        alarm_reg;
  logic [6:0]  code_reg;
  logic [4:0]  param_reg;
  logic        pairing_gp_reg;
  logic        captured_reg;
  logic [31:0] blink_cnt_reg;
  logic        blink_reg;
  logic [31:0] alt_cnt_reg;
  logic        alt_reg;
  logic        power_resolution_param;
  logic        ack_reg;
  logic        ready_on;
  logic [9:0]  power_kw;
  logic [9:0]  value;
  logic        numeric;
  logic        blank_lead;
  logic [7:0]  sym2;
  logic [7:0]  sym1;
  logic [7:0]  sym0;
  logic [7:0]  num2;
  logic [7:0]  num1;
  logic [7:0]  num0;
  logic [7:0]  d2;
  logic [7:0]  d1;
  logic [7:0]  d0;

  function automatic logic [9:0] sat(input logic [9:0] v,
                                     input logic [9:0] lim);
    sat = (v > lim) ? lim : v;
  endfunction

  // button filters, order mode, up, down, set
  assign btn_raw = {btn_set_i, btn_down_i, btn_up_i, btn_mode_i};
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_btn
      panel_debounce #(
        .CYCLES (DEBOUNCE_CYCLES)
      ) u_deb (
        .ref_clk_i (ref_clk_i),
        .rst_b_i   (rst_b_i),
        .raw_i     (btn_raw[gi]),
        .press_o   (press[gi])
      );
    end
  endgenerate

  assign p_mode = press[0];
  assign p_up   = press[1];
  assign p_down = press[2];
  assign p_set  = press[3];

  // pairing strap is caught after reset release, not by the reset itself
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      pairing_gp_reg <= 1'b0;
      captured_reg   <= 1'b0;
    end
    else if (!captured_reg)
    begin
      pairing_gp_reg <= drive_pairing_i;
      captured_reg   <= 1'b1;
    end
  end

  // mode sequence; a new alarm takes the display over
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      mode_reg <= panel_pkg::MODE_STATUS;
    else if (alarm_raise_i)
      mode_reg <= panel_pkg::MODE_ALARM;
    else if (p_mode)
    begin
      case (mode_reg)
        panel_pkg::MODE_STATUS: mode_reg <= panel_pkg::MODE_DIAG;
        panel_pkg::MODE_DIAG:   mode_reg <= panel_pkg::MODE_ALARM;
        panel_pkg::MODE_ALARM:  mode_reg <= panel_pkg::MODE_PARAM;
        panel_pkg::MODE_PARAM:  mode_reg <= panel_pkg::MODE_STATUS;
        default:                mode_reg <= panel_pkg::MODE_STATUS;
      endcase
    end
  end

  // status item selection
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      item_reg       <= 3'h0;
      show_value_reg <= 1'b0;
    end
    else if (mode_reg == panel_pkg::MODE_STATUS)
    begin
      if (p_up)
      begin
        item_reg       <= item_reg + 3'h1;
        show_value_reg <= 1'b0;
      end
      else if (p_down)
      begin
        item_reg       <= item_reg - 3'h1;
        show_value_reg <= 1'b0;
      end
      else if (p_set)
        show_value_reg <= ~show_value_reg;
    end
    else
      show_value_reg <= 1'b0;
  end

  // diagnostic screens and forced outputs
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      diag_reg     <= panel_pkg::DIAG_IO;
      force_on_reg <= 1'b0;
      force_reg    <= 8'h00;
      do_sel_reg   <= 3'h0;
    end
    else if (mode_reg != panel_pkg::MODE_DIAG)
    begin
      diag_reg     <= panel_pkg::DIAG_IO;
      force_on_reg <= 1'b0;
    end
    else if (force_on_reg)
    begin
      if (p_set)
        force_on_reg <= 1'b0;
      else if (p_up)
        do_sel_reg <= do_sel_reg + 3'h1;
      else if (p_down)
        force_reg[do_sel_reg] <= ~force_reg[do_sel_reg];
    end
    else if (p_set && diag_reg == panel_pkg::DIAG_FORCE)
    begin
      force_on_reg <= 1'b1;
      force_reg    <= do_normal_i;
    end
    else if (p_up)
      diag_reg <= (diag_reg == panel_pkg::DIAG_LAST) ?
                  panel_pkg::DIAG_IO : diag_reg + 2'h1;
    else if (p_down)
      diag_reg <= (diag_reg == panel_pkg::DIAG_IO) ?
                  panel_pkg::DIAG_LAST : diag_reg - 2'h1;
  end

  // outputs forced regardless of run state while forcing is on
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      io_connector_out_o <= 8'h00;
    else
      io_connector_out_o <= force_on_reg ? force_reg : do_normal_i;
  end

  // alarm latch; a new alarm beats a clear in the same cycle
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      alarm_reg <= 1'b0;
      code_reg  <= 7'h00;
    end
    else if (alarm_raise_i)
    begin
      alarm_reg <= 1'b1;
      code_reg  <= alarm_code_i;
    end
    else if (p_set && mode_reg == panel_pkg::MODE_ALARM && !alarm_cause_i)
      alarm_reg <= 1'b0;
  end

  // parameter number selection
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      param_reg <= 5'h00;
    else if (mode_reg == panel_pkg::MODE_PARAM)
    begin
      if (p_up)
        param_reg <= (param_reg == panel_pkg::PARAM_LAST) ?
                     5'h00 : param_reg + 5'h01;
      else if (p_down)
        param_reg <= (param_reg == 5'h00) ?
                     panel_pkg::PARAM_LAST : param_reg - 5'h01;
    end
  end

  // free-running blink and alternation timers
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      blink_cnt_reg <= 32'h0000_0000;
      blink_reg     <= 1'b0;
    end
    else if (blink_cnt_reg == 32'(BLINK_CYCLES - 1))
    begin
      blink_cnt_reg <= 32'h0000_0000;
      blink_reg     <= ~blink_reg;
    end
    else
      blink_cnt_reg <= blink_cnt_reg + 32'h0000_0001;
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      alt_cnt_reg <= 32'h0000_0000;
      alt_reg     <= 1'b0;
    end
    else if (alt_cnt_reg == 32'(ALT_CYCLES - 1))
    begin
      alt_cnt_reg <= 32'h0000_0000;
      alt_reg     <= ~alt_reg;
    end
    else
      alt_cnt_reg <= alt_cnt_reg + 32'h0000_0001;
  end

  // readiness and run permission
  assign ready_on = init_done_i & bus_established_i & forced_stop_input_i
                  & ~alarm_reg & (pairing_gp_reg | servo_on_i);

  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      run_enable_o   <= 1'b0;
      alarm_active_o <= 1'b0;
      ready_on_o     <= 1'b0;
    end
    else
    begin
      run_enable_o   <= ~alarm_reg & ~alarm_raise_i & forced_stop_input_i;
      alarm_active_o <= alarm_reg;
      ready_on_o     <= ready_on;
    end
  end

  // 0.1 kW units in, scaled down when whole kilowatts are chosen
  assign power_kw = power_resolution_param ?
                    sat(10'(power_now_i > 14'h03E7 ? 14'h03E7 : power_now_i),
                        panel_pkg::LIM_999) :
                    sat(10'((power_now_i / 14'h000A) > 14'h03E7 ?
                            14'h03E7 : power_now_i / 14'h000A),
                        panel_pkg::LIM_999);

  // screen content selection
  always_comb
  begin
    value      = 10'h000;
    numeric    = 1'b0;
    blank_lead = 1'b0;
    sym2       = panel_pkg::CH_BLANK;
    sym1       = panel_pkg::CH_BLANK;
    sym0       = panel_pkg::CH_BLANK;
    case (mode_reg)
      panel_pkg::MODE_STATUS:
      begin
        blank_lead = 1'b1;
        numeric    = show_value_reg && (item_reg != 3'h0);
        case (item_reg)
          3'h0:
          begin
            sym2 = panel_pkg::CH_R;
            sym1 = panel_pkg::CH_O;
            sym0 = ready_on ? panel_pkg::CH_N : panel_pkg::CH_F;
          end
          3'h1:
          begin
            value = sat(bus_voltage_i, panel_pkg::LIM_999);
            sym1  = panel_pkg::CH_P; // bus_voltage_tag
            sym0  = panel_pkg::CH_N;
          end
          3'h2:
          begin
            value = sat(eff_load_i, panel_pkg::LIM_300);
            sym0  = panel_pkg::CH_J;
          end
          3'h3:
          begin
            value = sat(peak_load_i, panel_pkg::LIM_400);
            sym0  = panel_pkg::CH_B;
          end
          3'h4:
          begin
            value = sat(regen_load_i, panel_pkg::LIM_300);
            sym0  = panel_pkg::CH_L;
          end
          3'h5:
          begin
            value = power_kw; // power_now_tag
            sym2  = panel_pkg::CH_P;
            sym1  = panel_pkg::CH_C;
            sym0  = panel_pkg::CH_1;
          end
          3'h6:
          begin
            value = sat(energy_kwh_i, panel_pkg::LIM_999);
            sym2  = panel_pkg::CH_T; // energy_kwh_tag
            sym1  = panel_pkg::CH_P;
            sym0  = panel_pkg::CH_1;
          end
          default:
          begin
            value = sat(energy_mwh_i, panel_pkg::LIM_999);
            sym2  = panel_pkg::CH_T; // energy_mwh_tag
            sym1  = panel_pkg::CH_P;
            sym0  = panel_pkg::CH_2;
          end
        endcase
      end
      panel_pkg::MODE_DIAG:
      begin
        case (diag_reg)
          panel_pkg::DIAG_IO:
          begin
            sym2 = io_connector_in_i;
            sym1 = io_connector_out_o;
          end
          panel_pkg::DIAG_FORCE:
          begin
            numeric = force_on_reg;
            value   = 10'(do_sel_reg) * 10'h00A +
                      10'(force_reg[do_sel_reg]);
            sym2    = panel_pkg::CH_DASH;
            sym1    = panel_pkg::CH_DASH;
            sym0    = panel_pkg::CH_DASH;
          end
          panel_pkg::DIAG_VER_LO:
          begin
            numeric = 1'b1;
            value   = panel_pkg::SW_VER_LO;
          end
          default:
          begin
            numeric = 1'b1;
            value   = panel_pkg::SW_VER_HI;
          end
        endcase
      end
      panel_pkg::MODE_ALARM:
      begin
        numeric = alarm_reg;
        value   = {3'h0, code_reg};
        sym1    = panel_pkg::CH_DASH;
        sym0    = panel_pkg::CH_DASH;
      end
      panel_pkg::MODE_PARAM:
      begin
        numeric = alt_reg;
        value   = {5'h00, param_reg} + 10'h001;
        sym1    = panel_pkg::CH_P;
        sym0    = panel_pkg::CH_A;
      end
      default:
      begin
        sym2 = panel_pkg::CH_DASH;
      end
    endcase
  end

  panel_digit_enc u_enc (
    .value_i (value),
    .seg2_o  (num2),
    .seg1_o  (num1),
    .seg0_o  (num0)
  );

  always_comb
  begin
    d2 = sym2;
    d1 = sym1;
    d0 = sym0;
    if (numeric)
    begin
      d0 = num0;
      d1 = (blank_lead && value < 10'h00A) ? panel_pkg::CH_BLANK : num1;
      d2 = (blank_lead && value < 10'h064) ? panel_pkg::CH_BLANK : num2;
      if (mode_reg == panel_pkg::MODE_ALARM)
        d2 = panel_pkg::CH_A;
      else if (mode_reg == panel_pkg::MODE_PARAM)
        d2 = panel_pkg::CH_BLANK;
    end
  end

  // registered segment drive, third digit dp blinks during an alarm except on the alarm screen
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      seg_digit2_o <= panel_pkg::CH_BLANK;
      seg_digit1_o <= panel_pkg::CH_BLANK;
      seg_digit0_o <= panel_pkg::CH_BLANK;
    end
    else
    begin
      seg_digit2_o <= (alarm_reg && blink_reg &&
                       mode_reg != panel_pkg::MODE_ALARM) ?
                      (d2 | panel_pkg::CH_DP) : d2;
      seg_digit1_o <= d1;
      seg_digit0_o <= d0;
    end
  end

  // avalon slave, one wait state on every access
  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_reg;

  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      ack_reg <= 1'b0;
    else
      ack_reg <= (avs_read_i | avs_write_i) & ~ack_reg;
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      power_resolution_param <= panel_pkg::CTRL_RST;
    else if (avs_write_i && ack_reg && avs_byteenable_i[0] &&
             avs_address_i == panel_pkg::OFS_CTRL)
      power_resolution_param <= avs_writedata_i[0];
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      avs_readdata_o <= 32'h0000_0000;
    else if (avs_read_i && !ack_reg)
    begin
      case (avs_address_i)
        panel_pkg::OFS_CTRL:
          avs_readdata_o <= {31'h0000_0000, power_resolution_param};
        panel_pkg::OFS_STATUS:
          avs_readdata_o <= {17'h0_0000, code_reg, 1'b0, run_enable_o,
                             ready_on_o, alarm_reg, mode_reg};
        panel_pkg::OFS_IO:
          avs_readdata_o <= {16'h0000, io_connector_in_i,
                             io_connector_out_o};
        default:
          avs_readdata_o <= 32'h0000_0000;
      endcase
    end
  end

endmodule // converter_front_panel_display

// ==== verif/panel_chk_sva.sv ====
// Purpose: port checks on the front-panel flags and bus wait
// Assumes: bound into converter_front_panel_display
// Notes:   mode is internal, so checks stay on visible flags
module panel_chk (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic drive_pairing_i,
  input wire logic init_done_i,
  input wire logic servo_on_i,
  input wire logic bus_established_i,
  input wire logic forced_stop_input_i,
  input wire logic alarm_raise_i,
  input wire logic alarm_cause_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic avs_waitrequest_o,
  input wire logic run_enable_o,
  input wire logic alarm_active_o,
  input wire logic ready_on_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);
  property p_fs; !forced_stop_input_i |=> !run_enable_o; endproperty
  a_fs: assert property (p_fs) else $error("run while stopped");
  // the flag output trails the internal latch by one clock
  property p_rs; alarm_raise_i |=> !run_enable_o ##1 alarm_active_o;
  endproperty
  a_rs: assert property (p_rs) else $error("alarm not taken");
  property p_rdy;
    ready_on_o |-> $past(init_done_i && bus_established_i
                         && forced_stop_input_i);
  endproperty
  a_rdy: assert property (p_rdy) else $error("ready too early");
  property p_net; ready_on_o && !drive_pairing_i |-> $past(servo_on_i);
  endproperty
  a_net: assert property (p_net) else $error("ready, servo off");
  property p_keep;
    alarm_active_o && $past(alarm_cause_i) |=> alarm_active_o;
  endproperty
  a_keep: assert property (p_keep) else $error("alarm lost");
  property p_new;
    !alarm_active_o && !$past(alarm_raise_i) |=> !alarm_active_o;
  endproperty
  a_new: assert property (p_new) else $error("alarm from nowhere");
  property p_ral; alarm_active_o |-> !ready_on_o; endproperty
  a_ral: assert property (p_ral) else $error("ready in alarm");
  // one wait state is promised, so a fresh request must stall
  property p_wt; $rose(avs_read_i || avs_write_i) |-> avs_waitrequest_o;
  endproperty
  a_wt: assert property (p_wt) else $error("no wait state");
endmodule // panel_chk

bind converter_front_panel_display panel_chk u_panel_chk (.*);

// ==== verif/panel_operator.sv ====
// Purpose: operator model pressing the four pushbuttons
// Assumes: index 0 mode, 1 up, 2 down, 3 set
// Notes:   a hold below the filter span models a bounce
module panel_operator (
  input  wire logic       ref_clk_i,
  output logic      [3:0] btn_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial btn_o = 4'h0;
  task automatic press(input int b, input int h);
    @(posedge ref_clk_i);
    btn_o[b] <= 1'b1;
    repeat (h) @(posedge ref_clk_i);
    btn_o[b] <= 1'b0;
    repeat (h) @(posedge ref_clk_i);
  endtask
endmodule // panel_operator

// ==== verif/converter_front_panel_display_tb.sv ====
// Purpose: self-checking bench for the front panel
// Assumes: short filter and blink spans keep the run quick
// Notes:   buttons go through the operator model
module converter_front_panel_display_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk_i = 1'b0, rst_b_i = 1'b0;
  logic btn_mode_i, btn_up_i, btn_down_i, btn_set_i;
  logic drive_pairing_i = 1'b0, servo_on_i = 1'b0;
  logic init_done_i = 1'b0, bus_established_i = 1'b0;
  logic forced_stop_input_i = 1'b1, alarm_raise_i = 1'b0;
  logic alarm_cause_i = 1'b1;
  logic [6:0] alarm_code_i = 7'h21;
  logic [9:0] bus_voltage_i = 10'h000, peak_load_i = 10'h3FF;
  wire  [9:0] eff_load_i = bus_voltage_i, regen_load_i = bus_voltage_i;
  wire  [9:0] energy_kwh_i = bus_voltage_i, energy_mwh_i = peak_load_i;
  wire  [13:0] power_now_i = {4'h0, bus_voltage_i};
  logic [7:0] io_connector_in_i = 8'h3C, do_normal_i = 8'hA5;
  logic [3:0] avs_address_i = 4'h0, avs_byteenable_i = 4'hF, btn, e;
  logic avs_read_i = 1'b0, avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0000_0000, avs_readdata_o, q;
  logic avs_waitrequest_o, run_enable_o, alarm_active_o, ready_on_o;
  logic [7:0] seg_digit2_o, seg_digit1_o, seg_digit0_o, io_connector_out_o;
  int failures = 0, cmp_count = 0;
  int lit_cnt, tag_cnt;
  assign {btn_set_i, btn_down_i, btn_up_i, btn_mode_i} = btn;
  always #5 ref_clk_i = ~ref_clk_i;
  converter_front_panel_display #(.DEBOUNCE_CYCLES(4), .BLINK_CYCLES(8),
    .ALT_CYCLES(16)) u_converter_front_panel_display (.*);
  panel_operator u_panel_operator (.ref_clk_i, .btn_o(btn));
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    cmp_count++;
    if (s !== x)
    begin
      failures++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask
  task automatic av(input logic w, input logic [3:0] a,
                    input logic [31:0] d, input logic [3:0] be);
    @(posedge ref_clk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_byteenable_i <= be;
    avs_write_i <= w;
    avs_read_i <= !w;
    @(posedge ref_clk_i);
    while (avs_waitrequest_o !== 1'b0) @(posedge ref_clk_i);
    q = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask
  // hold twice the filter span so release is accepted as well
  task automatic pr(input int b);
    u_panel_operator.press(b, 8);
    repeat (2) @(negedge ref_clk_i);
  endtask
  function automatic logic [31:0] dg();
    return {8'h00, seg_digit2_o, seg_digit1_o, seg_digit0_o};
  endfunction
  task automatic complete_run();
    $display("compares %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    #200_000;
    failures++;
    complete_run();
  end
  initial
  begin
    repeat (16) @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    repeat (4) @(negedge ref_clk_i);
    chk(ready_on_o, 1'b0);
    chk(dg(), {8'h00, panel_pkg::CH_R, panel_pkg::CH_O, panel_pkg::CH_F});
    @(posedge ref_clk_i);
    init_done_i <= 1'b1;
    bus_established_i <= 1'b1;
    repeat (4) @(negedge ref_clk_i);
    chk(ready_on_o, 1'b0);
    @(posedge ref_clk_i);
    servo_on_i <= 1'b1;
    bus_voltage_i <= 10'h3FF;
    repeat (4) @(negedge ref_clk_i);
    chk(dg(), {8'h00, panel_pkg::CH_R, panel_pkg::CH_O, panel_pkg::CH_N});
    $display("test ready done");
    pr(1);
    pr(3);
    chk(dg(), 32'h006F_6F6F);
    pr(3);
    pr(1);
    pr(1);
    pr(3);
    chk(dg(), 32'h0066_3F3F);
    pr(3);
    $display("test status done");
    e = 4'h2;
    repeat (4)
    begin
      pr(0);
      av(1'b0, panel_pkg::OFS_STATUS, 32'h0000_0000, 4'hF);
      chk(q[3:0], e);
      e = {e[2:0], e[3]};
    end
    pr(0);
    chk(seg_digit2_o, io_connector_in_i);
    pr(1);
    pr(3);
    pr(2);
    chk(io_connector_out_o, 8'hA4);
    repeat (3) pr(0);
    chk(io_connector_out_o, 8'hA5);
    $display("test modes done");
    @(posedge ref_clk_i);
    alarm_raise_i <= 1'b1;
    @(posedge ref_clk_i);
    alarm_raise_i <= 1'b0;
    av(1'b0, panel_pkg::OFS_STATUS, 32'h0000_0000, 4'hF);
    chk(q, 32'h0000_2114);
    pr(0);
    lit_cnt = 0;
    tag_cnt = 0;
    repeat (32)
    begin
      @(negedge ref_clk_i);
      lit_cnt += seg_digit2_o[7];
      tag_cnt += (seg_digit1_o == panel_pkg::CH_P);
    end
    chk(lit_cnt, 16);
    chk(tag_cnt, 16);
    repeat (3) pr(0);
    pr(3);
    chk(alarm_active_o, 1'b1);
    @(posedge ref_clk_i);
    alarm_cause_i <= 1'b0;
    pr(3);
    chk(alarm_active_o, 1'b0);
    chk(seg_digit0_o, panel_pkg::CH_DASH);
    chk(run_enable_o, 1'b1);
    @(posedge ref_clk_i);
    forced_stop_input_i <= 1'b0;
    repeat (3) @(negedge ref_clk_i);
    chk(run_enable_o, 1'b0);
    chk(ready_on_o, 1'b0);
    @(posedge ref_clk_i);
    forced_stop_input_i <= 1'b1;
    $display("test alarm done");
    av(1'b0, panel_pkg::OFS_CTRL, 32'h0000_0000, 4'hF);
    chk(q, 32'h0000_0000);
    av(1'b1, panel_pkg::OFS_CTRL, 32'h0000_0001, 4'h0);
    av(1'b0, panel_pkg::OFS_CTRL, 32'h0000_0000, 4'hF);
    chk(q, 32'h0000_0000);
    av(1'b1, panel_pkg::OFS_CTRL, 32'h0000_0001, 4'hF);
    av(1'b0, panel_pkg::OFS_CTRL, 32'h0000_0000, 4'hF);
    chk(q, 32'h0000_0001);
    av(1'b0, 4'hC, 32'h0000_0000, 4'hF);
    chk(q, 32'h0000_0000);
    u_panel_operator.press(0, 2);
    av(1'b0, panel_pkg::OFS_STATUS, 32'h0000_0000, 4'hF);
    chk(q[3:0], 4'h4);
    $display("test regs done");
    @(posedge ref_clk_i);
    rst_b_i <= 1'b0;
    drive_pairing_i <= 1'b1;
    servo_on_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    repeat (4) @(negedge ref_clk_i);
    chk(dg(), {8'h00, panel_pkg::CH_R, panel_pkg::CH_O, panel_pkg::CH_N});
    repeat (5) pr(1);
    pr(3);
    chk(dg(), 32'h0006_3F5B);
    $display("test restart done");
    complete_run();
  end
endmodule // converter_front_panel_display_tb
